// ===== pkg/mtc_pkg.sv
// Purpose: constants for the multichannel timer counter core
// Assumes: AHB-Lite register access, one word per register
// Notes:   channel blocks sit at CH_TAG, one 16-word block each
package mtc_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_RUN  = 12'h000;
  localparam logic [11:0] ADDR_SYNC = 12'h004;
  localparam logic [2:0]  CH_TAG    = 3'h2;   // haddr[11:9]
  localparam logic [3:0]  W_CTRL    = 4'h0;
  localparam logic [3:0]  W_MODE    = 4'h1;
  localparam logic [3:0]  W_PIN     = 4'h2;
  localparam logic [3:0]  W_IEN     = 4'h3;
  localparam logic [3:0]  W_STAT    = 4'h4;
  localparam logic [3:0]  W_CNT     = 4'h5;
  localparam logic [3:0]  W_GR0     = 4'h6;   // first..fourth at 6..9

  // ----------------------------------------------------------------
  // counter control fields
  // ----------------------------------------------------------------
  localparam logic [2:0] CLR_NONE = 3'h0;
  localparam logic [2:0] CLR_A    = 3'h1;
  localparam logic [2:0] CLR_B    = 3'h2;
  localparam logic [2:0] CLR_SYNC = 3'h3;
  localparam logic [2:0] CLR_C    = 3'h5;
  localparam logic [2:0] CLR_D    = 3'h6;
  localparam logic [1:0] CKS_DIV1  = 2'h0;
  localparam logic [1:0] CKS_DIV4  = 2'h1;
  localparam logic [1:0] CKS_DIV16 = 2'h2;
  localparam logic [1:0] CKS_EXT   = 2'h3;
  localparam int CKS_LSB = 3;

  // ----------------------------------------------------------------
  // pin control nibble per general register
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_OFF  = 2'h0;
  localparam logic [1:0] ACT_LOW  = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOG  = 2'h3;
  localparam int PIN_INIT_BIT = 2;
  localparam int PIN_CAP_BIT  = 3;

  // ----------------------------------------------------------------
  // status / enable layout and reset values
  // ----------------------------------------------------------------
  localparam int OVF_BIT = 4;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] GR_RESET  = 16'hffff;
  localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;

endpackage : mtc_pkg

// ===== verilog/mtc_core.sv
// Purpose: six-channel 16-bit timer counter with compare/capture
// Assumes: AHB-Lite slave, zero wait except read right after write
// Notes:   see channel block map in mtc_pkg
//
// Functional notes
// - six 16-bit counters, one per channel, software read/write
// - counters forced to zero by reset and hardware standby
// - counter and general registers accessed only as 16-bit words
// - sixteen general registers: four on channels 0,3, two elsewhere
// - first/second general registers work as compare or capture; third/fourth compare only
// - third/fourth registers buffer first/second on channels 0 and 3
// - run bits 0 to 5: zero halts, one counts
// - clearing run bit stops counter, pin keeps its level
// - pin-control write while stopped drives initial level at once
// - sync bit one joins channel to synchronous preset and clear
// - counter write loads all synchronised counters together
// - synchronous clear needs sync clear-source selection too
// - counters count up; free-running, synchronous, external event
// - free-running after reset; wrap sets overflow flag
// - overflow flag with enable requests interrupt
// - match with compare clearing sets flag and zeroes counter
// - match/capture flag with enable requests interrupt
// - compare match drives pin low, high or toggles
// - flag clears only by writing zero after reading one
// - capture copies counter into register and sets flag
`timescale 1ns/1ps

module mtc_core
#(
  parameter int PRE_W = 4
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        hw_standby,
  input  wire logic [5:0]  ext_clk_in,
  input  wire logic [11:0] pin_in,
  output wire [11:0]       pin_out,
  output wire [11:0]       pin_oe,
  output wire [5:0]        irq_req
);
  import mtc_pkg::*;

  if (PRE_W < 4) begin : g_chk
    $error("PRE_W must be at least 4");
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_ch(input logic [11:0] a);
    is_ch = (a[11:9] == CH_TAG) && (a[8:6] < 3'h6);
  endfunction : is_ch

  function automatic logic is_w16(input logic [11:0] a);
    is_w16 = (a[5:2] == W_CNT) || (a[5:2] >= W_GR0 && a[5:2] <= 4'h9);
  endfunction : is_w16

  // ----------------------------------------------------------------
  // input synchronisers and prescaler
  // ----------------------------------------------------------------
  logic [18:0]      sync1;
  logic [18:0]      sync2;
  logic [18:0]      sync3;
  logic [PRE_W-1:0] pre;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pre   <= '0;
    end
    else
    begin
      sync1 <= {hw_standby, ext_clk_in, pin_in};
      sync2 <= sync1;
      sync3 <= sync2;
      pre   <= pre + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  wire        stby     = sync2[18];
  wire [5:0]  ext_rise = sync2[17:12] & ~sync3[17:12];
  wire [11:0] pin_rise = sync2[11:0] & ~sync3[11:0];
  wire        tick4    = (pre[1:0] == 2'h3);
  wire        tick16   = (pre[3:0] == 4'hf);

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic [2:0]  wr_size;
  logic        rd_wait;
  logic [11:0] rd_addr_q;

  wire accept  = hsel && hready && (htrans[1] == HTRANS_NONSEQ_BIT[1]);
  wire rd_take = (accept && !hwrite && !wr_pend) || rd_wait;
  wire [11:0] rd_addr = rd_wait ? rd_addr_q : haddr[11:0];
  // byte writes to 16-bit registers are dropped; lane 0 only
  wire wr_ok = wr_pend && (wr_addr[1:0] == 2'h0) &&
               (!is_w16(wr_addr) || wr_size != 3'h0);
  wire         wr_is_ch = wr_ok && is_ch(wr_addr);
  wire [2:0]   wr_ch    = wr_addr[8:6];
  wire [3:0]   wr_word  = wr_addr[5:2];
  wire         rd_is_ch = is_ch(rd_addr);
  wire [2:0]   rd_ch    = rd_addr[8:6];
  wire [3:0]   rd_word  = rd_addr[5:2];

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      wr_size   <= '0;
      rd_wait   <= 1'b0;
      rd_addr_q <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend <= accept && hwrite;
      if (accept)
      begin
        wr_addr <= haddr[11:0];
        wr_size <= hsize;
      end
      // a read right behind a write waits one cycle for the update
      rd_wait   <= accept && !hwrite && wr_pend;
      hreadyout <= !(accept && !hwrite && wr_pend);
      if (accept && !hwrite)
        rd_addr_q <= haddr[11:0];
    end
  end

  // ----------------------------------------------------------------
  // global run and sync registers
  // ----------------------------------------------------------------
  logic [5:0] run;
  logic [5:0] sync;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run  <= '0;
      sync <= '0;
    end
    else if (wr_ok && wr_addr == ADDR_RUN)
      run  <= hwdata[5:0];
    else if (wr_ok && wr_addr == ADDR_SYNC)
      sync <= hwdata[5:0];
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  wire [5:0]  own_clr;
  wire [31:0] ch_rd [0:5];
  wire        sync_clr_any = |(own_clr & sync);

  for (genvar c = 0; c < 6; c++) begin : g_ch
    localparam bit HAS_CD = (c == 0) || (c == 3);
    logic [15:0] cnt;
    logic [15:0] gr [0:3];
    logic [7:0]  ctrl;
    logic [1:0]  mode;
    logic [15:0] pinc;
    logic [4:0]  ien;
    logic [4:0]  stat;
    logic [4:0]  armed;
    logic [1:0]  lvl;
    logic [1:0]  oe;
    logic        irq;
    logic [3:0]  match;
    logic [3:0]  cap;
    logic [31:0] rdv;

    wire [3:0] valid = HAS_CD ? 4'hf : 4'h3;
    wire [1:0] cks   = ctrl[CKS_LSB+1:CKS_LSB];
    wire       sel_tick = (cks == CKS_DIV1) ||
                          (cks == CKS_DIV4 && tick4) ||
                          (cks == CKS_DIV16 && tick16) ||
                          (cks == CKS_EXT && ext_rise[c]);
    wire tick  = run[c] && sel_tick && !stby;
    wire wsel  = wr_is_ch && (wr_ch == 3'(c));
    // preset reaches every synchronised counter at once
    wire cnt_wr = wr_is_ch && (wr_word == W_CNT) &&
                  ((wr_ch == 3'(c)) ||
                   (sync[c] && sync[wr_ch]));

    for (genvar i = 0; i < 4; i++) begin : g_gr
      wire cap_mode = pinc[4*i+PIN_CAP_BIT];
      assign match[i] = valid[i] && !cap_mode && tick &&
                        (cnt == gr[i]);
      if (i < 2) begin : g_pin
        assign cap[i] = cap_mode && pin_rise[2*c+i];
      end
      else begin : g_nopin
        assign cap[i] = 1'b0;
      end
    end

    wire [3:0] evt = match | cap;
    wire [2:0] clr_src = ctrl[2:0];
    assign own_clr[c] = (clr_src == CLR_A && evt[0]) ||
                        (clr_src == CLR_B && evt[1]) ||
                        (clr_src == CLR_C && evt[2]) ||
                        (clr_src == CLR_D && evt[3]);
    wire clr = own_clr[c] ||
               (clr_src == CLR_SYNC && sync[c] && sync_clr_any);
    wire ovf = tick && (cnt == 16'hffff) && !clr;
    wire [4:0] set_f = {ovf, evt & valid};
    wire [4:0] clr_f = (wsel && wr_word == W_STAT) ?
                       (armed & ~hwdata[4:0]) : 5'h00;
    wire pin_wr = wsel && (wr_word == W_PIN);

    // counter: standby, preset, clear, count
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
        cnt <= CNT_RESET;
      else if (stby)
        cnt <= CNT_RESET;
      else if (cnt_wr)
        cnt <= hwdata[15:0];
      else if (clr)
        cnt <= CNT_RESET;
      else if (tick)
        cnt <= cnt + 16'h0001;
    end

    // general registers, capture and buffer transfers
    for (genvar i = 0; i < 4; i++) begin : g_grr
      wire gwr = wsel && (wr_word == W_GR0 + 4'(i)) && valid[i];
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        // registers that a channel lacks stay at zero for reads
        if (!rst_n)
          gr[i] <= (HAS_CD || i < 2) ? GR_RESET : 16'h0000;
        else if (i < 2 && cap[i])
          gr[i] <= cnt;
        else if (i < 2 && HAS_CD && mode[i] && match[i])
          gr[i] <= gr[(i+2)%4];
        else if (i >= 2 && HAS_CD && mode[i%2] && cap[i%2])
          gr[i] <= gr[i%2];
        else if (gwr)
          gr[i] <= hwdata[15:0];
      end
    end

    // control, enables, flags
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ctrl  <= '0;
        mode  <= '0;
        pinc  <= '0;
        ien   <= '0;
        stat  <= '0;
        armed <= '0;
        irq   <= 1'b0;
      end
      else
      begin
        if (wsel && wr_word == W_CTRL)
          ctrl <= hwdata[7:0];
        if (wsel && wr_word == W_MODE)
          mode <= HAS_CD ? hwdata[1:0] : 2'h0;
        if (pin_wr)
          pinc <= HAS_CD ? hwdata[15:0] : {8'h00, hwdata[7:0]};
        if (wsel && wr_word == W_IEN)
          ien <= {hwdata[4], hwdata[3:0] & valid};
        stat <= (stat & ~clr_f) | set_f;              // set beats clear
        if (wsel && wr_word == W_STAT)
          armed <= '0;
        else if (rd_take && rd_is_ch && rd_ch == 3'(c) &&
                 rd_word == W_STAT)
          armed <= stat;
        irq <= |(stat & ien);
      end
    end

    // pin outputs for the first and second registers
    for (genvar i = 0; i < 2; i++) begin : g_out
      wire [1:0] act = pinc[4*i+1:4*i];
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          lvl[i] <= 1'b0;
          oe[i]  <= 1'b0;
        end
        else
        begin
          oe[i] <= (act != ACT_OFF) && !pinc[4*i+PIN_CAP_BIT];
          if (pin_wr && !run[c])
            lvl[i] <= hwdata[4*i+PIN_INIT_BIT];
          else if (match[i])
            unique case (act)
              ACT_LOW:  lvl[i] <= 1'b0;
              ACT_HIGH: lvl[i] <= 1'b1;
              ACT_TOG:  lvl[i] <= ~lvl[i];
              ACT_OFF:  lvl[i] <= lvl[i];
            endcase
        end
      end
      assign pin_out[2*c+i] = lvl[i];
      assign pin_oe[2*c+i]  = oe[i];
    end

    assign irq_req[c] = irq;

    // read view of this channel
    always_comb
    begin
      rdv = 32'h0000_0000;
      unique case (rd_word)
        W_CTRL: rdv = {24'h000000, ctrl};
        W_MODE: rdv = {30'h00000000, mode};
        W_PIN:  rdv = {16'h0000, pinc};
        W_IEN:  rdv = {27'h0000000, ien};
        W_STAT: rdv = {27'h0000000, stat};
        W_CNT:  rdv = {16'h0000, cnt};
        4'h6:   rdv = {16'h0000, gr[0]};
        4'h7:   rdv = {16'h0000, gr[1]};
        4'h8:   rdv = {16'h0000, gr[2]};
        4'h9:   rdv = {16'h0000, gr[3]};
        default: rdv = 32'h0000_0000;
      endcase
    end
    assign ch_rd[c] = rdv;
  end

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  wire [31:0] rd_mux = (rd_addr == ADDR_RUN)  ? {26'h0000000, run} :
                       (rd_addr == ADDR_SYNC) ? {26'h0000000, sync} :
                       rd_is_ch ? ch_rd[rd_ch] : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= '0;
    else if (rd_take)
      hrdata <= rd_mux;
  end

endmodule : mtc_core

// ===== sim/mtc_core_props.sv
// Purpose: port checks for mtc_core
// Assumes: sees only the ports of mtc_core
// Notes:   bound below the module
`timescale 1ns/1ps
module mtc_core_props
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [11:0] pin_oe,
  input wire logic [11:0] pin_out,
  input wire logic [5:0]  irq_req
);
  import mtc_pkg::*;
  // ----
  // taken transfers
  // ----
  wire tk    = hsel && hready && htrans == HTRANS_NONSEQ_BIT;
  wire rd_tk = tk && !hwrite;
  wire wr_tk = tk && hwrite;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |-> pin_oe == 12'h0 && irq_req == 6'h0 && hreadyout)
    else $error("outputs active in reset");
  chk_release_idle: assert property ($rose(rst_n) |-> hrdata == 32'h0)
    else $error("read data not clear after reset");
  chk_stall_one: assert property (!hreadyout |=> hreadyout)
    else $error("stall longer than one cycle");
  chk_stall_cause: assert property (!hreadyout |->
    $past(rd_tk) && $past(wr_tk, 2))
    else $error("stall without read after write");
  chk_rdata_hold: assert property ($changed(hrdata) |->
    $past(rd_tk) || $past(rd_tk, 2))
    else $error("read data changed without read");
  chk_irq_clear: assert property
    (($past(irq_req) & ~irq_req) != 6'h0 |->
    $past(wr_tk, 2) || $past(wr_tk, 3) || $past(wr_tk, 4))
    else $error("request dropped without write");
  chk_oe_cause: assert property ($changed(pin_oe) |->
    $past(wr_tk, 2) || $past(wr_tk, 3) || $past(wr_tk, 4))
    else $error("pin enable changed without write");
  cover property (!hreadyout);
  cover property ($rose(irq_req[3]));
  cover property ($rose(pin_out[6]));
endmodule : mtc_core_props

bind mtc_core mtc_core_props u_props (.sys_clk, .rst_n, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hrdata, .hresp, .pin_oe, .pin_out,
  .irq_req);

// ===== sim/testbench.sv
// Purpose: self-checking bench for mtc_core
// Assumes: one AHB-Lite master, slave ready is hready
// Notes:   external count clocks give exact tick counts
`timescale 1ns/1ps
module testbench;
  import mtc_pkg::*;
  logic        sys_clk    = 1'b0;
  logic        rst_n      = 1'b1;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [2:0]  hsize      = 3'h2;
  logic [31:0] hwdata     = 32'h0;
  logic        hw_standby = 1'b0;
  logic [5:0]  ext_clk_in = 6'h0;
  logic [11:0] pin_in     = 12'h0;
  wire         hready, hreadyout, hresp;
  wire [31:0]  hrdata;
  wire [11:0]  pin_out, pin_oe;
  wire [5:0]   irq_req;
  logic [31:0] exp_q[$];
  logic        rd_ph      = 1'b0;
  logic [15:0] v;
  logic [3:0]  pc[3]      = '{4'h3, 4'h5, 4'h2};
  logic        lv[3]      = '{1'b1, 1'b0, 1'b1};
  int          fail_count = 0;
  int          num_checks = 0;
  int          seed       = 6942;
  assign hready = hreadyout;
  always #20 sys_clk = ~sys_clk;
  mtc_core #(.PRE_W(4)) i_dut (.sys_clk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
    .hw_standby, .ext_clk_in, .pin_in, .pin_out, .pin_oe, .irq_req);
  // ----
  // bus and check tasks
  // ----
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] adr(int c, int w);
    return 32'(1024 + 64 * c + 4 * w);
  endfunction : adr
  task automatic aph(logic w, logic [31:0] a, logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ_BIT;
    hwrite <= w;
    hsize <= sz;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask : aph
  task automatic dph(logic [31:0] d);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask : dph
  task automatic wr(logic [31:0] a, logic [31:0] d, logic [2:0] sz = 3'h2);
    aph(1'b1, a, sz);
    dph(d);
  endtask : wr
  task automatic rd(logic [31:0] a, logic [31:0] e);
    exp_q.push_back(e);
    aph(1'b0, a, 3'h2);
    dph(32'h0);
  endtask : rd
  // read address phase overlaps the write data phase
  task automatic wr_rd(logic [31:0] a, logic [15:0] d);
    exp_q.push_back({16'h0, d});
    aph(1'b1, a, 3'h2);
    hwrite <= 1'b0;
    hwdata <= {16'h0, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    dph(32'h0);
  endtask : wr_rd
  task automatic pulse(logic [5:0] m, int n);
    repeat (n)
    begin
      ext_clk_in <= m;
      repeat (4) @(posedge sys_clk);
      ext_clk_in <= 6'h0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : pulse
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  always @(posedge sys_clk)
  begin
    if (rd_ph && hreadyout === 1'b1)
      check("hrdata", hrdata, exp_q.pop_front());
    if (hreadyout === 1'b1)
      rd_ph = hsel && htrans == HTRANS_NONSEQ_BIT && !hwrite;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
  // ----
  // scenarios
  // ----
  initial
  begin
    rst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_RUN, 32'h0);
    rd(ADDR_SYNC, 32'h0);
    rd(adr(0, W_GR0), {16'h0, GR_RESET});
    rd(32'h0fc, 32'h0);
    for (int c = 0; c < 6; c++)
    begin
      rd(adr(c, W_CNT), 32'h0);
      for (int r = 0; r < ((c % 3 == 0) ? 4 : 2); r++)
      begin
        v = $random(seed);
        wr(adr(c, W_GR0 + r), {16'ha5a5, v});
        rd(adr(c, W_GR0 + r), {16'h0, v});
      end
      v = $random(seed);
      wr(adr(c, W_CNT), {16'h0, v});
      wr(adr(c, W_CNT), 32'h1234, 3'h0);
      rd(adr(c, W_CNT), {16'h0, v});
    end
    wr(adr(1, W_GR0 + 2), 32'h77);
    rd(adr(1, W_GR0 + 2), 32'h0);
    v = $random(seed);
    wr_rd(adr(5, W_CNT), v);
    wr(adr(2, W_CTRL), 32'h18);
    wr(adr(2, W_CNT), 32'h0);
    wr(ADDR_RUN, 32'h04);
    pulse(6'h04, 5);
    wr(ADDR_RUN, 32'h0);
    pulse(6'h04, 2);
    rd(adr(2, W_CNT), 32'h5);
    // keep compare matches away from the wrap
    wr(adr(1, W_GR0), 32'h8000);
    wr(adr(1, W_GR0 + 1), 32'h8000);
    wr(adr(1, W_CTRL), 32'h18);
    wr(adr(1, W_IEN), 32'h10);
    wr(adr(1, W_CNT), 32'hfffe);
    wr(ADDR_RUN, 32'h02);
    pulse(6'h02, 2);
    rd(adr(1, W_CNT), 32'h0);
    check("irq1", irq_req[1], 1'b1);
    rd(adr(1, W_STAT), 32'h10);
    wr(adr(1, W_STAT), 32'h1f);
    wr(adr(1, W_STAT), 32'h0);
    rd(adr(1, W_STAT), 32'h10);
    wr(adr(1, W_STAT), 32'h0);
    rd(adr(1, W_STAT), 32'h0);
    check("irq1_off", irq_req[1], 1'b0);
    wr(adr(3, W_GR0), 32'h3);
    wr(adr(3, W_CTRL), 32'h19);
    wr(adr(3, W_IEN), 32'h1);
    wr(adr(3, W_CNT), 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      wr(ADDR_RUN, 32'h0);
      wr(adr(3, W_PIN), {28'h0, pc[k]});
      repeat (3) @(posedge sys_clk);
      check("pin_init", pin_out[6], pc[k][2]);
      check("pin_oe", pin_oe[6], 1'b1);
      wr(ADDR_RUN, 32'h08);
      pulse(6'h08, 3);
      rd(adr(3, W_CNT), 32'h3);
      check("pin_hold", pin_out[6], pc[k][2]);
      pulse(6'h08, 1);
      wr(ADDR_RUN, 32'h0);
      repeat (3) @(posedge sys_clk);
      check("pin_match", pin_out[6], lv[k]);
      rd(adr(3, W_CNT), 32'h0);
    end
    check("irq3", irq_req[3], 1'b1);
    wr(ADDR_SYNC, 32'h11);
    wr(adr(0, W_CTRL), 32'h19);
    wr(adr(4, W_CTRL), 32'h1b);
    wr(adr(0, W_GR0), 32'h2);
    v = $random(seed);
    wr(adr(4, W_CNT), {16'h0, v});
    rd(adr(0, W_CNT), {16'h0, v});
    wr(adr(0, W_CNT), 32'h0);
    wr(ADDR_RUN, 32'h11);
    pulse(6'h11, 3);
    rd(adr(4, W_CNT), 32'h0);
    wr(ADDR_RUN, 32'h0);
    wr(adr(0, W_GR0 + 2), 32'h9);
    wr(adr(0, W_MODE), 32'h1);
    wr(ADDR_RUN, 32'h01);
    pulse(6'h01, 3);
    rd(adr(0, W_GR0), 32'h9);
    wr(ADDR_RUN, 32'h0);
    wr(adr(1, W_PIN), 32'h8);
    v = $random(seed);
    wr(adr(1, W_CNT), {16'h0, v});
    rd(adr(0, W_CNT), 32'h0);
    pin_in <= 12'h004;
    repeat (6) @(posedge sys_clk);
    rd(adr(1, W_GR0), {16'h0, v});
    rd(adr(1, W_STAT), 32'h1);
    hw_standby <= 1'b1;
    repeat (5) @(posedge sys_clk);
    hw_standby <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(adr(1, W_CNT), 32'h0);
    wr(ADDR_RUN, 32'h3f);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_RUN, 32'h0);
    finish_test();
  end
endmodule : testbench
